/* rtl/acq_playback_pkg.sv */
// Purpose: shared constants and carrier types for the acquisition and playback DMA block
// Assumes: one 100 MHz clock; timing buses arrive as synchronous qualifiers
// Notes: register offsets are byte addresses on a 32-bit register port
package acq_playback_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_CH = 3;
  localparam int BANK_AW = 6;
  localparam int LL_AW = 6;
  localparam int LL_ENTRIES = 64;
  localparam int WAVE_AW = 8;
  localparam logic [1:0] META_WORDS = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] REG_CHCFG0 = 8'h00;
  localparam logic [7:0] REG_CHSTAT0 = 8'h10;
  localparam logic [7:0] REG_SYNC = 8'h20;
  localparam logic [7:0] REG_TSTAMP = 8'h24;
  localparam logic [7:0] REG_PBCTL = 8'h28;
  localparam logic [7:0] REG_PBSTAT = 8'h2C;
  localparam logic [7:0] REG_LLIDX = 8'h30;
  localparam logic [7:0] REG_LLW0 = 8'h34;
  localparam logic [7:0] REG_LLW1 = 8'h38;
  localparam logic [7:0] REG_WADDR = 8'h3C;
  localparam logic [7:0] REG_WDATA = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // Channel config fields and reset values
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_TRANSIENT = 3;
  localparam int CFG_GATEMODE = 4;
  localparam int CFG_EN = 5;
  localparam int CFG_META = 6;
  localparam int CFG_LEN_LSB = 16;
  localparam logic [31:0] CHCFG_RST = 32'h0000_0000;
  localparam logic SYNC_MASTER_RST = 1'b0;
  localparam logic [2:0] SRC_TEST = 3'h3;
  localparam logic [2:0] SRC_LOOP = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic smp;
    logic sync;
    logic gate;
  } timing_bus_t;

  typedef struct packed {
    logic meta;
    logic [31:0] data;
  } dma_beat_t;

  typedef struct packed {
    logic last;
    logic host;
    logic [11:0] reps;
    logic [15:0] delay;
    logic [15:0] len;
    logic [15:0] addr;
  } ll_entry_t;

endpackage

/* rtl/acq_playback_dma.sv */
// Purpose: three acquisition DMA channels and a linked-list playback controller
// Assumes: timing bus strobes are synchronous to clk, host answers fetches in order
// Notes: banks are small on-chip arrays standing in for the external memory banks
// Operation
// R1: Each channel picks any converter input, the test generator or playback loopback.
// R2: Each channel owns a bank used as FIFO or transient capture store.
// R3: Each bank has a DMA engine streaming its samples to the host.
// R4: Gate-driven mode ends the transfer when the acquisition gate falls.
// R5: Optional metadata packet carries channel id, sample time stamp and length.
// R6: Playback walks linked entries, fetching from on-board or host memory.
// R7: Each entry has its own length, delay from trigger and repeat count; later entries count delay from the end of the previous one.
// R8: At most 64 entries chain into one sequence, played in order.
// R9: Acquisition and playback each have a timing bus: clock, sync, gate.
// R10: Slave takes timing from the sync bus; master drives it out.
// R11: Gate-driven length field carries the count actually captured.
module acq_playback_dma
  import acq_playback_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Converter inputs
  input wire logic [2:0][15:0] adcData,
  // Internal timing buses
  input wire timing_bus_t acqBusInt,
  input wire timing_bus_t pbBusInt,
  // Multi-board sync bus
  input wire timing_bus_t syncBusIn,
  output timing_bus_t syncBusOut,
  output logic [2:0] syncBusOe_n,
  output logic masterMode,
  // DMA streams to host
  output dma_beat_t [NUM_CH-1:0] dmaBeat,
  output logic [NUM_CH-1:0] dmaValid,
  input wire logic [NUM_CH-1:0] dmaReady,
  // Host memory fetch
  output logic hostRdReq,
  output logic [31:0] hostRdAddr,
  input wire logic hostRdValid,
  input wire logic [31:0] hostRdData,
  // D/A sample stream
  output logic dacValid,
  output logic [31:0] dacData
);

  typedef enum logic [1:0] {CH_IDLE, CH_CAPT, CH_DRAIN} ch_state_t;
  typedef enum logic [2:0] {PB_IDLE, PB_ARM, PB_DELAY, PB_FETCH, PB_PLAY} pb_state_t;

  function automatic logic [15:0] pickSample(input logic [2:0] sel,
      input logic [2:0][15:0] adc, input logic [15:0] tst, input logic [15:0] loopS);
    case (sel)
      3'h0, 3'h1, 3'h2: pickSample = adc[sel[1:0]];
      SRC_TEST: pickSample = tst;
      SRC_LOOP: pickSample = loopS;
      default: pickSample = 16'h0000;
    endcase
  endfunction

  function automatic logic isChanReg(input logic [7:0] a, input logic [7:0] base, input int ch);
    isChanReg = (a == base + 8'(4 * ch));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Timing buses and sync bus
  logic master_r;
  timing_bus_t acqBus;
  timing_bus_t pbBus;
  logic gatePrev_r;
  logic trigPrev_r;
  logic [31:0] tstamp_r;
  logic [15:0] testGen_r;

  // R10 slave follows bus
  assign acqBus = master_r ? acqBusInt : syncBusIn;
  assign pbBus = master_r ? pbBusInt : syncBusIn;
  // R10 master drives bus
  assign syncBusOut = acqBusInt;
  assign syncBusOe_n = master_r ? 3'h0 : 3'h7;
  assign masterMode = master_r;

  // R9 edges of each gate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gatePrev_r <= 1'b0;
      trigPrev_r <= 1'b0;
    end else begin
      gatePrev_r <= acqBus.gate;
      trigPrev_r <= pbBus.gate;
    end
  end

  // R5 sample-accurate time, zeroed by sync
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tstamp_r <= 32'h0000_0000;
      testGen_r <= 16'h0000;
    end else if (acqBus.sync) begin
      tstamp_r <= 32'h0000_0000;
      testGen_r <= 16'h0000;
    end else if (acqBus.smp) begin
      tstamp_r <= tstamp_r + 32'h0000_0001;
      testGen_r <= testGen_r + 16'h0001;
    end
  end

  wire gateRise = acqBus.gate & ~gatePrev_r;
  wire gateFall = ~acqBus.gate & gatePrev_r;
  wire trigRise = pbBus.gate & ~trigPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  logic [31:0] chCfg_r [NUM_CH];
  logic [LL_AW-1:0] llIdx_r;
  logic [WAVE_AW-1:0] waveAddr_r;
  ll_entry_t llTab [LL_ENTRIES];
  logic [31:0] waveMem [2**WAVE_AW];
  wire pbStart = regWr && regAddr == REG_PBCTL && regWrData[0];
  wire pbAbort = regWr && regAddr == REG_PBCTL && regWrData[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        chCfg_r[c] <= CHCFG_RST;
      end
      master_r <= SYNC_MASTER_RST;
      llIdx_r <= '0;
      waveAddr_r <= '0;
    end else if (regWr) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (isChanReg(regAddr, REG_CHCFG0, c)) begin
          chCfg_r[c] <= regWrData;
        end
      end
      if (regAddr == REG_SYNC) begin
        master_r <= regWrData[0];
      end
      if (regAddr == REG_LLIDX) begin
        llIdx_r <= regWrData[LL_AW-1:0];
      end
      if (regAddr == REG_WADDR) begin
        waveAddr_r <= regWrData[WAVE_AW-1:0];
      end
      // Auto-increment lets software load a waveform with one address write
      if (regAddr == REG_WDATA) begin
        waveAddr_r <= waveAddr_r + 1'b1;
      end
    end
  end

  // Memories carry no reset; contents are loaded by software before use
  always_ff @(posedge clk) begin
    if (regWr && regAddr == REG_LLW0) begin
      llTab[llIdx_r].addr <= regWrData[15:0];
      llTab[llIdx_r].len <= regWrData[31:16];
    end
    if (regWr && regAddr == REG_LLW1) begin
      llTab[llIdx_r].delay <= regWrData[15:0];
      llTab[llIdx_r].reps <= regWrData[27:16];
      llTab[llIdx_r].host <= regWrData[28];
      llTab[llIdx_r].last <= regWrData[29];
    end
    if (regWr && regAddr == REG_WDATA) begin
      waveMem[waveAddr_r] <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition channels
  logic [15:0] capCount_r [NUM_CH];
  logic [NUM_CH-1:0] ovr_r;
  logic [NUM_CH-1:0] chBusy;
  logic [31:0] dacData_r;

  generate
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      ch_state_t st_r;
      logic [15:0] bank [2**BANK_AW];
      logic [BANK_AW:0] wrPtr_r;
      logic [BANK_AW:0] rdPtr_r;
      logic [31:0] stamp_r;
      logic [1:0] metaIdx_r;
      dma_beat_t beat_r;
      logic valid_r;
      logic [15:0] sample;
      logic full;
      logic capEnd;
      logic metaPend;
      logic sendMeta;
      logic sendData;
      logic take;

      wire en = chCfg_r[ch][CFG_EN];
      wire transient = chCfg_r[ch][CFG_TRANSIENT];
      wire gateMode = chCfg_r[ch][CFG_GATEMODE];
      wire [15:0] fixLen = chCfg_r[ch][CFG_LEN_LSB +: 16];
      wire ovrClr = regWr && isChanReg(regAddr, REG_CHSTAT0, ch) && regWrData[0];
      wire capWr = st_r == CH_CAPT && acqBus.smp && !full;

      // R1 source select
      assign sample = pickSample(chCfg_r[ch][CFG_SRC_LSB +: 3], adcData, testGen_r,
                                 dacData_r[15:0]);
      assign full = (wrPtr_r - rdPtr_r) == (BANK_AW + 1)'(2**BANK_AW);
      // R4 gate end closes the link
      assign capEnd = !en || (gateMode ? gateFall : (capCount_r[ch] + 16'(capWr)) >= fixLen)
                      || (transient && full);
      assign metaPend = chCfg_r[ch][CFG_META] && metaIdx_r != META_WORDS;
      // R5 metadata leads a transient store, trails a FIFO stream
      assign sendMeta = st_r == CH_DRAIN && metaPend && (transient || rdPtr_r == wrPtr_r);
      assign sendData = rdPtr_r != wrPtr_r && (!transient || (st_r == CH_DRAIN && !metaPend));
      assign take = !valid_r || dmaReady[ch];
      assign chBusy[ch] = st_r != CH_IDLE;

      // R2 bank write, capture control
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          st_r <= CH_IDLE;
          wrPtr_r <= '0;
          capCount_r[ch] <= 16'h0000;
          stamp_r <= 32'h0000_0000;
        end else begin
          case (st_r)
            CH_IDLE: begin
              if (en && gateRise) begin
                st_r <= CH_CAPT;
                capCount_r[ch] <= 16'h0000;
                stamp_r <= tstamp_r;
              end
            end
            CH_CAPT: begin
              if (capWr) begin
                wrPtr_r <= wrPtr_r + 1'b1;
                capCount_r[ch] <= capCount_r[ch] + 16'h0001;
              end
              if (capEnd) begin
                st_r <= CH_DRAIN;
              end
            end
            CH_DRAIN: begin
              if (rdPtr_r == wrPtr_r && !metaPend) begin
                st_r <= CH_IDLE;
              end
            end
            default: st_r <= CH_IDLE;
          endcase
        end
      end

      always_ff @(posedge clk) begin
        if (capWr) begin
          bank[wrPtr_r[BANK_AW-1:0]] <= sample;
        end
      end

      // FIFO overrun is sticky; a new overrun beats a clear in the same cycle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ovr_r[ch] <= 1'b0;
        end else begin
          ovr_r[ch] <= (ovr_r[ch] && !ovrClr) || (st_r == CH_CAPT && acqBus.smp && full);
        end
      end

      // R3 DMA sender to host
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          rdPtr_r <= '0;
          metaIdx_r <= 2'h0;
          beat_r <= '0;
          valid_r <= 1'b0;
        end else begin
          if (st_r == CH_IDLE) begin
            metaIdx_r <= 2'h0;
          end
          if (take) begin
            valid_r <= sendMeta || sendData;
            if (sendMeta) begin
              beat_r.meta <= 1'b1;
              metaIdx_r <= metaIdx_r + 2'h1;
              // R11 captured count in length field
              beat_r.data <= (metaIdx_r == 2'h0) ? {2'(ch), 14'h0000, capCount_r[ch]}
                                                 : stamp_r;
            end else if (sendData) begin
              beat_r.meta <= 1'b0;
              beat_r.data <= {16'h0000, bank[rdPtr_r[BANK_AW-1:0]]};
              rdPtr_r <= rdPtr_r + 1'b1;
            end
          end
        end
      end

      assign dmaBeat[ch] = beat_r;
      assign dmaValid[ch] = valid_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Playback controller
  pb_state_t pb_r;
  logic [LL_AW-1:0] pbIdx_r;
  logic [15:0] pbPos_r;
  logic [11:0] pbRep_r;
  logic [15:0] pbDelay_r;
  logic [31:0] pbWord_r;
  logic dacValid_r;
  ll_entry_t ent;
  ll_entry_t entNext;

  assign ent = llTab[pbIdx_r];
  assign entNext = llTab[pbIdx_r + 1'b1];
  // R6 host fetch held until answered
  assign hostRdReq = pb_r == PB_FETCH && ent.host;
  assign hostRdAddr = {16'h0000, ent.addr + pbPos_r};

  // R6 walk the linked list
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pb_r <= PB_IDLE;
      pbIdx_r <= '0;
      pbPos_r <= 16'h0000;
      pbRep_r <= 12'h000;
      pbDelay_r <= 16'h0000;
      pbWord_r <= 32'h0000_0000;
      dacData_r <= 32'h0000_0000;
      dacValid_r <= 1'b0;
    end else begin
      dacValid_r <= 1'b0;
      if (pbAbort) begin
        pb_r <= PB_IDLE;
      end else begin
        case (pb_r)
          PB_IDLE: begin
            if (pbStart) begin
              pb_r <= PB_ARM;
              pbIdx_r <= '0;
            end
          end
          // R7 delay counted from trigger
          PB_ARM: begin
            if (trigRise) begin
              pb_r <= PB_DELAY;
              pbPos_r <= 16'h0000;
              pbRep_r <= 12'h000;
              pbDelay_r <= ent.delay;
            end
          end
          PB_DELAY: begin
            if (pbDelay_r == 16'h0000) begin
              pb_r <= PB_FETCH;
            end else if (pbBus.smp) begin
              pbDelay_r <= pbDelay_r - 16'h0001;
            end
          end
          PB_FETCH: begin
            if (!ent.host) begin
              pbWord_r <= waveMem[WAVE_AW'(ent.addr + pbPos_r)];
              pb_r <= PB_PLAY;
            end else if (hostRdValid) begin
              pbWord_r <= hostRdData;
              pb_r <= PB_PLAY;
            end
          end
          PB_PLAY: begin
            if (pbBus.smp) begin
              dacData_r <= pbWord_r;
              dacValid_r <= 1'b1;
              pb_r <= PB_FETCH;
              // R7 length then repeats
              if (pbPos_r + 16'h0001 < ent.len) begin
                pbPos_r <= pbPos_r + 16'h0001;
              end else if (pbRep_r + 12'h001 < ent.reps) begin
                pbPos_r <= 16'h0000;
                pbRep_r <= pbRep_r + 12'h001;
              // R8 chain ends at last flag or entry 64
              end else if (ent.last || pbIdx_r == LL_AW'(LL_ENTRIES - 1)) begin
                pb_r <= PB_IDLE;
              end else begin
                pbIdx_r <= pbIdx_r + 1'b1;
                pbPos_r <= 16'h0000;
                pbRep_r <= 12'h000;
                pbDelay_r <= entNext.delay;
                pb_r <= PB_DELAY;
              end
            end
          end
          default: pb_r <= PB_IDLE;
        endcase
      end
    end
  end

  assign dacValid = dacValid_r;
  assign dacData = dacData_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register reads: data stands only in the cycle after the strobe
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0000_0000;
    for (int c = 0; c < NUM_CH; c++) begin
      if (isChanReg(regAddr, REG_CHCFG0, c)) begin
        rdMux = chCfg_r[c];
      end
      if (isChanReg(regAddr, REG_CHSTAT0, c)) begin
        rdMux = {capCount_r[c], 14'h0000, chBusy[c], ovr_r[c]};
      end
    end
    case (regAddr)
      REG_SYNC: rdMux = {31'h0, master_r};
      REG_TSTAMP: rdMux = tstamp_r;
      REG_PBSTAT: rdMux = {16'h0000, 2'h0, pbIdx_r, 5'h00, 3'(pb_r)};
      REG_LLIDX: rdMux = {26'h0, llIdx_r};
      REG_WADDR: rdMux = {24'h0, waveAddr_r};
      default: ;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= regRd ? rdMux : 32'h0000_0000;
    end
  end

endmodule

/* tb/acq_playback_chk.sv */
// Purpose: port checks for the acquisition and playback DMA block
// Assumes: one clock, rst asynchronous and active high
// Notes: bound to every instance of the block
module acq_playback_chk
  import acq_playback_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  // Timing
  input wire timing_bus_t acqBusInt,
  input wire timing_bus_t pbBusInt,
  input wire timing_bus_t syncBusIn,
  input wire timing_bus_t syncBusOut,
  input wire logic [2:0] syncBusOe_n,
  input wire logic masterMode,
  // Streams
  input wire dma_beat_t [NUM_CH-1:0] dmaBeat,
  input wire logic [NUM_CH-1:0] dmaValid,
  input wire logic [NUM_CH-1:0] dmaReady,
  input wire logic hostRdReq,
  input wire logic [31:0] hostRdAddr,
  input wire logic hostRdValid,
  input wire logic dacValid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  property p_oe_mode;
    syncBusOe_n == (masterMode ? 3'h0 : 3'h7);
  endproperty
  a_oe_mode: assert property (p_oe_mode)
    else $error("sync bus enables disagree with mode");
  property p_sync_copy;
    masterMode |-> syncBusOut == acqBusInt;
  endproperty
  a_sync_copy: assert property (p_sync_copy)
    else $error("master does not drive internal timing out");
  property p_sync_read;
    regRd && regAddr == REG_SYNC |=> regRdData[0] == masterMode;
  endproperty
  a_sync_read: assert property (p_sync_read)
    else $error("mode readback differs from mode output");
  property p_dma_hold;
    dmaValid[0] && !dmaReady[0] |=> dmaValid[0] && $stable(dmaBeat[0]);
  endproperty
  a_dma_hold: assert property (p_dma_hold)
    else $error("beat changed or dropped before acceptance");
  property p_dma_fall;
    $fell(dmaValid[1]) |-> $past(dmaReady[1]);
  endproperty
  a_dma_fall: assert property (p_dma_fall)
    else $error("valid fell without acceptance");
  property p_dac_smp;
    dacValid |-> ($past(masterMode) ? $past(pbBusInt.smp) : $past(syncBusIn.smp));
  endproperty
  a_dac_smp: assert property (p_dac_smp)
    else $error("sample played without a playback strobe");
  property p_host_hold;
    hostRdReq && !hostRdValid && !(regWr && regAddr == REG_PBCTL)
      |=> hostRdReq && $stable(hostRdAddr);
  endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("fetch request dropped before answer");
  property p_host_addr;
    hostRdReq |-> hostRdAddr[31:16] == 16'h0;
  endproperty
  a_host_addr: assert property (p_host_addr)
    else $error("fetch address upper half not zero");

  c_meta: cover property (dmaValid[0] && dmaReady[0] && dmaBeat[0].meta);
  c_host: cover property (hostRdReq && hostRdValid);
  c_dac: cover property (dacValid);
endmodule

bind acq_playback_dma acq_playback_chk acq_playback_chk_inst (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .acqBusInt(acqBusInt), .pbBusInt(pbBusInt), .syncBusIn(syncBusIn),
  .syncBusOut(syncBusOut), .syncBusOe_n(syncBusOe_n), .masterMode(masterMode),
  .dmaBeat(dmaBeat), .dmaValid(dmaValid), .dmaReady(dmaReady), .hostRdReq(hostRdReq),
  .hostRdAddr(hostRdAddr), .hostRdValid(hostRdValid), .dacValid(dacValid));

/* tb/host_model.sv */
// Purpose: host side of the DMA streams and playback fetch port
// Assumes: fetch word at an address is {~addr[15:0], addr[15:0]}
// Notes: stall holds off beats; latency sets fetch answer delay
module host_model
  import acq_playback_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench controls
  input wire logic stall,
  input wire logic [3:0] latency,
  // DMA streams
  input wire dma_beat_t [NUM_CH-1:0] dmaBeat,
  input wire logic [NUM_CH-1:0] dmaValid,
  output logic [NUM_CH-1:0] dmaReady,
  // Fetch port
  input wire logic hostRdReq,
  input wire logic [31:0] hostRdAddr,
  output logic hostRdValid,
  output logic [31:0] hostRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  dma_beat_t beatQ[NUM_CH][$];
  logic [3:0] waitCnt;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dmaReady <= '0;
      waitCnt <= 4'h0;
      hostRdValid <= 1'b0;
      hostRdData <= 32'h0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (dmaValid[c] && dmaReady[c]) beatQ[c].push_back(dmaBeat[c]);
      end
      dmaReady <= {NUM_CH{!stall}};
      // Data never lingers once the answer cycle has passed
      if (!hostRdReq || hostRdValid) begin
        waitCnt <= 4'h0;
        hostRdValid <= 1'b0;
        hostRdData <= ~hostRdData;
      end else if (waitCnt == latency) begin
        hostRdValid <= 1'b1;
        hostRdData <= {~hostRdAddr[15:0], hostRdAddr[15:0]};
      end else begin
        waitCnt <= waitCnt + 4'h1;
        hostRdData <= ~hostRdData;
      end
    end
  end
endmodule

/* tb/test_acquisition_playback_dma.sv */
// Purpose: directed scenarios for the acquisition and playback DMA block
// Assumes: host model answers fetches three cycles late
// Notes: master mode is set first so the internal buses time both paths
module test_acquisition_playback_dma
  import acq_playback_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst, regWr, regRd, stall, hostRdValid, hostRdReq, dacValid, masterMode;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, hostRdAddr, hostRdData, dacData;
  logic [2:0][15:0] adcData;
  timing_bus_t acqBusInt, pbBusInt, syncBusIn, syncBusOut;
  logic [2:0] syncBusOe_n, dmaValid, dmaReady;
  dma_beat_t [NUM_CH-1:0] dmaBeat;
  logic [31:0] dacQ[$];
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  acq_playback_dma acq_playback_dma_inst (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .adcData(adcData), .acqBusInt(acqBusInt), .pbBusInt(pbBusInt), .syncBusIn(syncBusIn),
    .syncBusOut(syncBusOut), .syncBusOe_n(syncBusOe_n), .masterMode(masterMode),
    .dmaBeat(dmaBeat), .dmaValid(dmaValid), .dmaReady(dmaReady), .hostRdReq(hostRdReq),
    .hostRdAddr(hostRdAddr), .hostRdValid(hostRdValid), .hostRdData(hostRdData),
    .dacValid(dacValid), .dacData(dacData));
  host_model host_model_inst (.clk(clk), .rst(rst), .stall(stall), .latency(4'h3),
    .dmaBeat(dmaBeat), .dmaValid(dmaValid), .dmaReady(dmaReady), .hostRdReq(hostRdReq),
    .hostRdAddr(hostRdAddr), .hostRdValid(hostRdValid), .hostRdData(hostRdData));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard well above the few hundred cycles the tests need
  always @(posedge clk) begin
    if (dacValid === 1'b1) dacQ.push_back(dacData);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    rd(REG_CHCFG0, d);
    chk(d, CHCFG_RST);
    rd(REG_SYNC, d);
    chk(d, {31'h0, SYNC_MASTER_RST});
    chk({29'h0, syncBusOe_n}, 32'h7);
    wr(REG_SYNC, 32'h1);
    rd(REG_SYNC, d);
    chk(d, 32'h1);
    chk({29'h0, syncBusOe_n}, 32'h0);
    rd(8'hFC, d);
    chk(d, 32'h0);
    $display("register test done");
  endtask

  task automatic t_acq();
    dma_beat_t b;
    for (int c = 0; c < NUM_CH; c++) wr(REG_CHCFG0 + 8'(4 * c), 32'h70 | 32'(2 - c));
    stall <= 1'b1;
    @(posedge clk);
    acqBusInt.gate <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      acqBusInt.smp <= 1'b1;
      adcData <= {16'h3000 + 16'(k), 16'h2000 + 16'(k), 16'h1000 + 16'(k)};
      @(posedge clk);
      acqBusInt.smp <= 1'b0;
    end
    @(posedge clk);
    acqBusInt.gate <= 1'b0;
    repeat (10) @(posedge clk);
    stall <= 1'b0;
    repeat (40) @(posedge clk);
    for (int c = 0; c < NUM_CH; c++) begin
      chk(32'(host_model_inst.beatQ[c].size()), 32'h5);
      for (int k = 0; k < 5; k++) begin
        b = host_model_inst.beatQ[c][k];
        chk({31'h0, b.meta}, {31'h0, k > 2});
        if (k < 3) chk({16'h0, b.data[15:0]}, 32'(4096 * (3 - c) + k));
        if (k == 3) chk(b.data, {2'(c), 14'h0, 16'h3});
      end
    end
    $display("acquisition test done");
  endtask

  task automatic t_play();
    logic [31:0] d;
    logic [31:0] exp[5] = '{32'hA0A0_0001, 32'hA0A0_0002, 32'hA0A0_0001,
      32'hA0A0_0002, 32'hFFEF_0010};
    wr(REG_WADDR, 32'h0);
    wr(REG_WDATA, exp[0]);
    wr(REG_WDATA, exp[1]);
    wr(REG_LLIDX, 32'h0);
    wr(REG_LLW0, 32'h0002_0000);
    wr(REG_LLW1, 32'h0002_0001);
    wr(REG_LLIDX, 32'h1);
    wr(REG_LLW0, 32'h0001_0010);
    wr(REG_LLW1, 32'h3001_0000);
    wr(REG_PBCTL, 32'h1);
    rd(REG_PBSTAT, d);
    chk(d & 32'h7, 32'h1);
    @(posedge clk);
    pbBusInt.gate <= 1'b1;
    for (int i = 0; i < 400 && dacQ.size() < 5; i++) begin
      @(posedge clk);
      pbBusInt.smp <= ~pbBusInt.smp;
    end
    @(posedge clk);
    pbBusInt <= '0;
    chk(32'(dacQ.size()), 32'h5);
    for (int i = 0; i < 5; i++) chk(dacQ[i], exp[i]);
    rd(REG_PBSTAT, d);
    chk(d & 32'h7, 32'h0);
    $display("playback test done");
  endtask

  // Sync zeroes ramp and stamp; fixed length 2 ends capture with gate still high
  task automatic t_trans();
    logic [31:0] d;
    wr(REG_CHCFG0, 32'h0002_006B);
    @(posedge clk);
    acqBusInt.sync <= 1'b1;
    @(posedge clk);
    acqBusInt <= 3'h1;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      acqBusInt.smp <= ~acqBusInt.smp;
    end
    repeat (10) @(posedge clk);
    acqBusInt.gate <= 1'b0;
    chk(32'(host_model_inst.beatQ[0].size()), 32'h9);
    chk(host_model_inst.beatQ[0][5].data, 32'h2);
    chk(host_model_inst.beatQ[0][6].data, 32'h0);
    for (int k = 0; k < 2; k++) chk(host_model_inst.beatQ[0][7 + k].data, 32'(k));
    rd(REG_CHSTAT0, d);
    chk(d, 32'h0002_0000);
    $display("transient test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    regAddr = 8'h0;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    stall = 1'b0;
    adcData = '0;
    acqBusInt = '0;
    pbBusInt = '0;
    syncBusIn = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_acq();
    t_play();
    t_trans();
    results();
  end
endmodule
